// ### rtl/sfx_defines.svh
// constants for the overflow / underflow / inexact response unit
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef SFX_DEFINES_SVH
`define SFX_DEFINES_SVH

// =========================================
// register map
`define SFX_CTRL_OFS 4'h0
`define SFX_LAST_OFS 4'h4

// =========================================
// control register fields
`define SFX_FLG_OVF 0
`define SFX_FLG_UNF 1
`define SFX_FLG_PRC 2
`define SFX_MSK_LSB 3
`define SFX_RM_LSB 6
`define SFX_CTRL_RST 32'h0000_0038

// =========================================
// rounding mode codes
`define SFX_RM_NEAR 2'h0
`define SFX_RM_DOWN 2'h1
`define SFX_RM_UP 2'h2
`define SFX_RM_ZERO 2'h3

// =========================================
// exponent limits, biases and scale factors (true exponents)
`define SFX_SGL_EMAX 14'sh007F
`define SFX_SGL_EMIN 14'sh3F82
`define SFX_SGL_BIAS 14'sh007F
`define SFX_SGL_SCALE 14'sh00C0
`define SFX_DBL_EMAX 14'sh03FF
`define SFX_DBL_EMIN 14'sh3C02
`define SFX_DBL_BIAS 14'sh03FF
`define SFX_DBL_SCALE 14'sh0600

// =========================================
// special encodings
`define SFX_SGL_EXP_MAX 8'hFE
`define SFX_SGL_EXP_INF 8'hFF
`define SFX_SGL_FRAC_ONES 23'h7F_FFFF
`define SFX_DBL_EXP_MAX 11'h7FE
`define SFX_DBL_EXP_INF 11'h7FF
`define SFX_DBL_FRAC_ONES 52'hF_FFFF_FFFF_FFFF

`endif

// ### rtl/sfx_pkg.sv
// types shared by the response unit and its bench
// assumes the defines header is compiled alongside
package sfx_pkg;

   // one arithmetic result handed over by the datapath
   typedef struct packed {
      logic dbl;                 // destination is double precision
      logic conv;                // conversion to integer: only inexact applies
      logic trunc;               // truncating conversion, rounds toward zero
      logic zero;                // exact result is zero
      logic sign;                // result sign
      logic signed [13:0] exp;   // unbounded true exponent after rounding
      logic [51:0] frac;         // rounded fraction, single uses [51:29]
      logic inexact;             // unbounded-exponent rounding lost bits
      logic [63:0] bounded;      // bounded-exponent rounded result
      logic bnd_inexact;         // bounded-exponent rounding lost bits
   } sfx_req_type;

   typedef struct packed {
      logic [63:0] result;       // delivered result, single in [31:0]
      logic ovf;                 // overflow flag set
      logic unf;                 // underflow flag set
      logic prec;                // precision flag set
      logic trap;                // unmasked condition, exception raised
   } sfx_resp_type;

endpackage

// ### rtl/sfx_resp.sv
// overflow, underflow and inexact result / flag logic for fp results
// assumes an upstream datapath supplies unbounded and bounded roundings
`include "sfx_defines.svh"

module sfx_resp
   import sfx_pkg::*;
(
   input wire logic core_clk,            // core clock, 10 MHz
   input wire logic reset_n,             // synchronous reset, active low
   input wire logic ce,                  // clock enable, freezes all state when low
   input wire logic req_valid,           // result offered this cycle
   input wire sfx_req_type req,          // result to be checked
   output sfx_resp_type resp,            // delivered result and flags
   output logic resp_valid,              // resp holds a new answer
   output logic fp_exception,            // one-cycle exception request
   input wire logic [3:0] avs_address,   // byte address
   input wire logic avs_read,            // read strobe
   input wire logic avs_write,           // write strobe
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata,     // read data
   output logic avs_waitrequest          // stall until access completes
);

   // =========================================
   // state
   logic [2:0] status_flags_ff;   // overflow_flag_alt, underflow_flag, precision_flag
   logic [2:0] nxt_status_flags;
   logic [2:0] exc_mask_ff;
   logic [2:0] nxt_exc_mask;
   logic [1:0] round_mode_ff;
   logic [1:0] nxt_round_mode;
   sfx_resp_type resp_ff;
   sfx_resp_type nxt_resp;
   logic resp_valid_ff;
   logic nxt_resp_valid;
   logic [3:0] last_ff;
   logic [3:0] nxt_last;
   logic bus_ack_ff;
   logic nxt_bus_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   // =========================================
   // result evaluation
   logic [1:0] eff_rm;
   logic ovf_cond;
   logic unf_cond;
   logic ovf_masked;
   logic unf_masked;
   logic prc_masked;
   logic pick_inf;
   logic signed [13:0] emax;
   logic signed [13:0] emin;
   logic signed [13:0] bias;
   logic signed [13:0] scale;
   logic signed [13:0] scaled_fld;
   logic [63:0] max_res;
   logic [63:0] inf_res;
   logic [63:0] scaled_res;
   logic [63:0] res_val;
   logic ovf_set;
   logic unf_set;
   logic prc_set;
   logic trap_set;

   always_comb
   begin
      // truncating conversions ignore the user mode
      eff_rm = req.trunc ? `SFX_RM_ZERO : round_mode_ff;
      ovf_masked = exc_mask_ff[`SFX_FLG_OVF];
      unf_masked = exc_mask_ff[`SFX_FLG_UNF];
      prc_masked = exc_mask_ff[`SFX_FLG_PRC];
      emax = req.dbl ? `SFX_DBL_EMAX : `SFX_SGL_EMAX;
      emin = req.dbl ? `SFX_DBL_EMIN : `SFX_SGL_EMIN;
      bias = req.dbl ? `SFX_DBL_BIAS : `SFX_SGL_BIAS;
      scale = req.dbl ? `SFX_DBL_SCALE : `SFX_SGL_SCALE;
      // exponent is taken after rounding, so a carry into the next binade counts
      ovf_cond = !req.conv && !req.zero && (req.exp > emax);
      unf_cond = !req.conv && !req.zero && (req.exp < emin);
      unique case (eff_rm)
         `SFX_RM_NEAR: pick_inf = 1'b1;
         `SFX_RM_DOWN: pick_inf = req.sign;
         `SFX_RM_UP:   pick_inf = !req.sign;
         `SFX_RM_ZERO: pick_inf = 1'b0;
      endcase
      if (req.dbl)
      begin
         max_res = {req.sign, `SFX_DBL_EXP_MAX, `SFX_DBL_FRAC_ONES};
         inf_res = {req.sign, `SFX_DBL_EXP_INF, 52'h0_0000_0000_0000};
      end
      else
      begin
         max_res = {32'h0000_0000, req.sign, `SFX_SGL_EXP_MAX, `SFX_SGL_FRAC_ONES};
         inf_res = {32'h0000_0000, req.sign, `SFX_SGL_EXP_INF, 23'h00_0000};
      end
      // wrapped exponent: down for overflow, up for underflow
      scaled_fld = ovf_cond ? (req.exp - scale + bias) : (req.exp + scale + bias);
      if (req.dbl)
         scaled_res = {req.sign, scaled_fld[10:0], req.frac};
      else
         scaled_res = {32'h0000_0000, req.sign, scaled_fld[7:0], req.frac[51:29]};

      res_val = req.bounded;
      ovf_set = 1'b0;
      unf_set = 1'b0;
      prc_set = 1'b0;
      if (ovf_cond && !ovf_masked)
      begin
         res_val = scaled_res;
         ovf_set = 1'b1;
         prc_set = req.inexact;
      end
      else if (ovf_cond)
      begin
         // also the path taken when only precision is unmasked
         res_val = pick_inf ? inf_res : max_res;
         ovf_set = 1'b1;
         prc_set = 1'b1;
      end
      else if (unf_cond && !unf_masked)
      begin
         res_val = scaled_res;
         unf_set = 1'b1;
         prc_set = req.inexact;
      end
      else if (unf_cond)
      begin
         // zero, denormal or normal as rounded upstream
         res_val = req.bounded;
         unf_set = req.bnd_inexact;
         prc_set = req.bnd_inexact;
      end
      else
      begin
         res_val = req.bounded;
         prc_set = req.bnd_inexact;
      end
      trap_set = (ovf_set && !ovf_masked) || (unf_set && !unf_masked)
                 || (prc_set && !prc_masked);
   end

   // =========================================
   // response and flag registers
   logic bus_wr;
   logic bus_rd;
   logic take;

   assign take = ce && req_valid;
   assign bus_wr = avs_write && !bus_ack_ff && (avs_address == `SFX_CTRL_OFS);
   assign bus_rd = avs_read && !bus_ack_ff;

   always_comb
   begin
      nxt_resp = resp_ff;
      nxt_resp_valid = 1'b0;
      nxt_last = last_ff;
      nxt_status_flags = status_flags_ff;
      nxt_exc_mask = exc_mask_ff;
      nxt_round_mode = round_mode_ff;
      if (bus_wr)
      begin
         nxt_status_flags = avs_writedata[`SFX_FLG_PRC:`SFX_FLG_OVF];
         nxt_exc_mask = avs_writedata[`SFX_MSK_LSB +: 3];
         nxt_round_mode = avs_writedata[`SFX_RM_LSB +: 2];
      end
      if (take)
      begin
         nxt_resp = '{result: res_val, ovf: ovf_set, unf: unf_set,
                      prec: prc_set, trap: trap_set};
         nxt_resp_valid = 1'b1;
         nxt_last = {trap_set, prc_set, unf_set, ovf_set};
         // sticky flags: a new event wins over a software clear
         nxt_status_flags = nxt_status_flags | {prc_set, unf_set, ovf_set};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         resp_ff <= '0;
         resp_valid_ff <= 1'b0;
         last_ff <= 4'h0;
         status_flags_ff <= 3'(`SFX_CTRL_RST);
         exc_mask_ff <= 3'(`SFX_CTRL_RST >> `SFX_MSK_LSB);
         round_mode_ff <= `SFX_RM_NEAR;
      end
      else if (ce)
      begin
         resp_ff <= nxt_resp;
         resp_valid_ff <= nxt_resp_valid;
         last_ff <= nxt_last;
         status_flags_ff <= nxt_status_flags;
         exc_mask_ff <= nxt_exc_mask;
         round_mode_ff <= nxt_round_mode;
      end
   end

   assign resp = resp_ff;
   assign resp_valid = resp_valid_ff;
   // flags are already in place when the exception is seen
   assign fp_exception = resp_valid_ff && resp_ff.trap;

   // =========================================
   // register bus: one wait cycle, then the answer
   always_comb
   begin
      nxt_bus_ack = (avs_read || avs_write) && !bus_ack_ff;
      nxt_rdata = rdata_ff;
      if (bus_rd)
      begin
         unique case (avs_address)
            `SFX_CTRL_OFS: nxt_rdata = {24'h00_0000, round_mode_ff, exc_mask_ff,
                                        status_flags_ff};
            `SFX_LAST_OFS: nxt_rdata = {28'h000_0000, last_ff};
            default:       nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         bus_ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end
      else if (ce)
      begin
         bus_ack_ff <= nxt_bus_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_ff;
   assign avs_readdata = rdata_ff;

   // =========================================
   // checks
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence take_s;
      ce && req_valid;
   endsequence

   sequence answer_s;
      resp_valid;
   endsequence

   // flags of the last answer must all be found in the sticky copy
   sequence flags_in_s;
      (status_flags_ff & last_ff[2:0]) == last_ff[2:0];
   endsequence

   resp_timing_a: assert property (take_s |=> answer_s)
      else $error("no response one cycle after request");

   sgl_ovf_det_a: assert property (
      take_s and (!req.dbl && !req.conv && !req.zero && req.exp > `SFX_SGL_EMAX)
      |=> resp.ovf)
      else $error("single overflow missed");

   dbl_ovf_det_a: assert property (
      take_s and (req.dbl && !req.conv && !req.zero && req.exp > `SFX_DBL_EMAX)
      |=> resp.ovf)
      else $error("double overflow missed");

   sgl_unf_det_a: assert property (
      take_s and (!req.dbl && !req.conv && !req.zero && req.exp < `SFX_SGL_EMIN
      && !exc_mask_ff[`SFX_FLG_UNF]) |=> resp.unf)
      else $error("single underflow missed");

   dbl_unf_det_a: assert property (
      take_s and (req.dbl && !req.conv && !req.zero && req.exp < `SFX_DBL_EMIN
      && !exc_mask_ff[`SFX_FLG_UNF]) |=> resp.unf)
      else $error("double underflow missed");

   masked_ovf_sgl_a: assert property (
      take_s and (!req.dbl && ovf_cond && ovf_masked && eff_rm == `SFX_RM_ZERO)
      |=> resp.prec && resp.result[30:0] == {`SFX_SGL_EXP_MAX, `SFX_SGL_FRAC_ONES})
      else $error("masked single overflow result wrong");

   masked_ovf_dbl_a: assert property (
      take_s and (req.dbl && ovf_cond && ovf_masked && eff_rm == `SFX_RM_NEAR)
      |=> resp.prec && resp.result[62:52] == `SFX_DBL_EXP_INF)
      else $error("masked double overflow result wrong");

   unm_ovf_scale_a: assert property (
      take_s and (req.dbl && ovf_cond && !ovf_masked)
      |=> resp.result[62:52] == $past(req.exp[10:0]) - 11'h201
      && resp.prec == $past(req.inexact))
      else $error("unmasked overflow not scaled by 2^1536");

   unm_unf_scale_a: assert property (
      take_s and (!req.dbl && unf_cond && !unf_masked)
      |=> resp.result[30:23] == $past(req.exp[7:0]) + 8'h3F)
      else $error("unmasked underflow not scaled by 2^192");

   masked_unf_a: assert property (
      take_s and (unf_cond && unf_masked)
      |=> resp.unf == $past(req.bnd_inexact) && resp.result == $past(req.bounded))
      else $error("masked underflow response wrong");

   inexact_flag_a: assert property (
      take_s and (!ovf_cond && !unf_cond)
      |=> resp.prec == $past(req.bnd_inexact)
      && (status_flags_ff[`SFX_FLG_PRC] || !resp.prec))
      else $error("precision flag not set on inexact result");

   trunc_mode_a: assert property (
      take_s and (req.trunc && ovf_cond && ovf_masked)
      |=> resp.result != $past(inf_res))
      else $error("truncation did not round toward zero");

   trap_raise_a: assert property (
      take_s and (prc_set && !prc_masked)
      |=> fp_exception && resp.prec)
      else $error("unmasked precision did not raise exception");

   prec_unm_res_a: assert property (
      take_s and (!ovf_cond && !unf_cond && !prc_masked)
      |=> resp.result == $past(req.bounded))
      else $error("unmasked precision changed the bounded result");

   sticky_flags_a: assert property (take_s |=> flags_in_s)
      else $error("sticky flags lost a new event");

   exc_flags_a: assert property (fp_exception |-> flags_in_s)
      else $error("exception raised before flags were set");

   flags_hold_a: assert property (!take && !bus_wr |=> $stable(status_flags_ff))
      else $error("status flags changed without cause");

endmodule

// ### verification/test_simd_fp_ovf_unf_inexact_resp.sv
// self-checking bench for the overflow / underflow / inexact response unit
// assumes the unit answers one cycle after a take and the bus answers in two cycles
`include "sfx_defines.svh"

module test_simd_fp_ovf_unf_inexact_resp
   import sfx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // =========================================
   // signals
   logic core_clk, reset_n, ce, req_valid, resp_valid, fp_exception;
   logic avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdata;
   sfx_req_type req;
   sfx_resp_type resp, got;
   logic got_vld, got_exc;
   int err_total, tests_run;
   localparam logic [51:0] FR = 52'hA_5A5A_5A5A_5A5A;
   localparam logic [63:0] LO = 64'h0000_0000_FFFF_FFFF;
   localparam logic [63:0] ALL = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] BND = 64'h0000_0000_0012_3457;

   sfx_resp DUT (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .req_valid(req_valid),
      .req(req), .resp(resp), .resp_valid(resp_valid), .fp_exception(fp_exception),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   // =========================================
   // shared tasks
   task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask

   // waitrequest and read data are taken as they stand at the rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         n++;
         @(posedge core_clk);
      end
      chk("waitrequest", 64'h0, 64'(avs_waitrequest));
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, 64'(e), 64'(rdata));
   endtask

   task automatic set_ctrl(input logic [1:0] rm, input logic [2:0] msk);
      bus(1'b1, `SFX_CTRL_OFS, {24'h00_0000, rm, msk, 3'b000});
   endtask

   function automatic sfx_req_type mk(input logic dbl, input logic s, input int e,
                                      input logic inx, input logic binx);
      sfx_req_type r;
      r = '0;
      r.dbl = dbl;
      r.sign = s;
      r.exp = 14'(e);
      r.frac = FR;
      r.inexact = inx;
      r.bounded = BND;
      r.bnd_inexact = binx;
      return r;
   endfunction

   task automatic issue(input sfx_req_type r);
      @(posedge core_clk);
      req <= r;
      req_valid <= 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
      @(negedge core_clk);
      got = resp;
      got_vld = resp_valid;
      got_exc = fp_exception;
   endtask

   // fl is {trap, prec, unf, ovf}
   task automatic expect_resp(input string what, input logic [63:0] res,
                              input logic [63:0] m, input logic [3:0] fl);
      chk(what, res & m, got.result & m);
      chk("flags", 64'(fl), 64'({got.trap, got.prec, got.unf, got.ovf}));
      chk("resp_valid", 64'h1, 64'(got_vld));
      chk("fp_exception", 64'(fl[3]), 64'(got_exc));
   endtask

   function automatic logic [63:0] ovf_val(input logic dbl, input logic s, input logic [1:0] rm);
      logic inf;
      inf = (rm == `SFX_RM_NEAR) || (rm == `SFX_RM_DOWN && s) || (rm == `SFX_RM_UP && !s);
      if (dbl)
         return {s, inf ? {`SFX_DBL_EXP_INF, 52'h0} : {`SFX_DBL_EXP_MAX, `SFX_DBL_FRAC_ONES}};
      return {32'h0, s, inf ? {`SFX_SGL_EXP_INF, 23'h0} : {`SFX_SGL_EXP_MAX, `SFX_SGL_FRAC_ONES}};
   endfunction

   // =========================================
   // scenarios
   task automatic t_regs();
      rd("ctrl reset", `SFX_CTRL_OFS, 32'h0000_0038);
      rd("last reset", `SFX_LAST_OFS, 32'h0000_0000);
      bus(1'b1, `SFX_LAST_OFS, 32'hFFFF_FFFF);
      rd("last read only", `SFX_LAST_OFS, 32'h0000_0000);
      rd("unmapped", 4'hC, 32'h0000_0000);
   endtask

   task automatic t_ovf_masked();
      for (int d = 0; d < 2; d++)
         for (int rm = 0; rm < 4; rm++)
            for (int s = 0; s < 2; s++)
            begin
               set_ctrl(2'(rm), 3'b111);
               issue(mk(1'(d), 1'(s), d ? 1024 : 128, 1'b1, 1'b1));
               expect_resp("ovf masked", ovf_val(1'(d), 1'(s), 2'(rm)), ALL, 4'b0101);
            end
      issue(mk(1'b0, 1'b0, 127, 1'b0, 1'b0));
      expect_resp("single max exp", BND, LO, 4'b0000);
      issue(mk(1'b1, 1'b1, 1023, 1'b0, 1'b0));
      expect_resp("double max exp", BND, ALL, 4'b0000);
   endtask

   task automatic t_ovf_unmasked();
      set_ctrl(`SFX_RM_NEAR, 3'b110);
      issue(mk(1'b0, 1'b1, 130, 1'b0, 1'b1));
      expect_resp("ovf single scaled", {32'h0, 1'b1, 8'(130 - 192 + 127), FR[51:29]}, LO, 4'b1001);
      issue(mk(1'b1, 1'b0, 1100, 1'b1, 1'b1));
      expect_resp("ovf double scaled", {1'b0, 11'(1100 - 1536 + 1023), FR}, ALL, 4'b1101);
   endtask

   task automatic t_unf();
      sfx_req_type r;
      set_ctrl(`SFX_RM_NEAR, 3'b111);
      issue(mk(1'b0, 1'b0, -127, 1'b1, 1'b1));
      expect_resp("unf masked inexact", BND, LO, 4'b0110);
      issue(mk(1'b1, 1'b1, -1023, 1'b0, 1'b0));
      expect_resp("unf masked exact", BND, ALL, 4'b0000);
      issue(mk(1'b0, 1'b0, -126, 1'b0, 1'b0));
      expect_resp("single min exp", BND, LO, 4'b0000);
      r = mk(1'b0, 1'b0, -200, 1'b0, 1'b0);
      r.zero = 1'b1;
      issue(r);
      expect_resp("zero result", BND, LO, 4'b0000);
      set_ctrl(`SFX_RM_NEAR, 3'b101);
      issue(mk(1'b1, 1'b0, -1030, 1'b1, 1'b1));
      expect_resp("unf double scaled", {1'b0, 11'(-1030 + 1536 + 1023), FR}, ALL, 4'b1110);
      issue(mk(1'b0, 1'b1, -150, 1'b0, 1'b1));
      expect_resp("unf single scaled", {32'h0, 1'b1, 8'(-150 + 192 + 127), FR[51:29]}, LO, 4'b1010);
   endtask

   task automatic t_prec();
      sfx_req_type r;
      set_ctrl(`SFX_RM_NEAR, 3'b111);
      issue(mk(1'b1, 1'b0, 5, 1'b1, 1'b1));
      expect_resp("prec masked", BND, ALL, 4'b0100);
      r = mk(1'b0, 1'b0, 0, 1'b1, 1'b1);
      r.conv = 1'b1;
      issue(r);
      expect_resp("conversion inexact", BND, LO, 4'b0100);
      r.trunc = 1'b1;
      r.exp = 14'sd200;
      issue(r);
      expect_resp("trunc conversion", BND, LO, 4'b0100);
      set_ctrl(`SFX_RM_ZERO, 3'b011);
      issue(mk(1'b0, 1'b0, 3, 1'b1, 1'b1));
      expect_resp("prec unmasked", BND, LO, 4'b1100);
      issue(mk(1'b0, 1'b1, 200, 1'b1, 1'b1));
      expect_resp("prec with masked ovf", ovf_val(1'b0, 1'b1, `SFX_RM_ZERO), LO, 4'b1101);
   endtask

   task automatic t_trunc_sticky();
      sfx_req_type r;
      set_ctrl(`SFX_RM_NEAR, 3'b111);
      r = mk(1'b0, 1'b0, 129, 1'b1, 1'b1);
      r.trunc = 1'b1;
      issue(r);
      expect_resp("trunc ovf", ovf_val(1'b0, 1'b0, `SFX_RM_ZERO), LO, 4'b0101);
      issue(mk(1'b0, 1'b0, -130, 1'b1, 1'b1));
      rd("sticky flags", `SFX_CTRL_OFS, 32'h0000_003F);
      rd("last flags", `SFX_LAST_OFS, 32'h0000_0006);
      // a frozen clock enable must swallow the offered result
      @(posedge core_clk);
      ce <= 1'b0;
      req_valid <= 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
      ce <= 1'b1;
      @(negedge core_clk);
      chk("resp_valid frozen", 64'h0, 64'(resp_valid));
   endtask

   task automatic t_reset();
      set_ctrl(`SFX_RM_UP, 3'b000);
      issue(mk(1'b0, 1'b0, 140, 1'b1, 1'b1));
      expect_resp("ovf all unmasked", {32'h0, 1'b0, 8'(140 - 192 + 127), FR[51:29]},
                  LO, 4'b1101);
      // a second reset in mid-run must bring back the idle state
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      chk("resp after reset", 64'h0, resp.result);
      chk("outputs after reset", 64'h0,
          64'({resp_valid, fp_exception, resp.trap, resp.prec, resp.unf, resp.ovf}));
      rd("ctrl after reset", `SFX_CTRL_OFS, 32'h0000_0038);
      rd("last after reset", `SFX_LAST_OFS, 32'h0000_0000);
   endtask

   // =========================================
   // clock, reset, sequence and verdict
   task automatic summarize();
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = !core_clk;
   end

   initial
   begin
      #400000;
      err_total++;
      summarize();
   end

   initial
   begin
      err_total = 0;
      tests_run = 0;
      reset_n = 1'b0;
      ce = 1'b1;
      req_valid = 1'b0;
      req = '0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_regs();
      t_ovf_masked();
      t_ovf_unmasked();
      t_unf();
      t_prec();
      t_trunc_sticky();
      t_reset();
      summarize();
   end
endmodule
